// ===== src/ows_wiper_slave.sv
// Two-wire slave core for the one-time-programmable wiper
`timescale 1ns/1ps
`default_nettype none
`include "ows_defines.svh"
module ows_wiper_slave (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N_O,
  input wire logic ADDR_SELECT_PIN_I,
  input wire logic FUSE_DONE_I,
  input wire logic FUSE_OK_I,
  output logic FUSE_BLOW_O,
  output logic [5:0] WIPER_CODE_O,
  output logic [1:0] FUSE_CHECK_O
);
  ows_link_if link ();
  ows_pkg::ows_state_t state;
  logic [4:0] s_pins;
  logic scl_s;
  logic sda_s;
  logic done_s;
  logic ok_s;
  logic sel_s;
  logic scl_d;
  logic sda_d;
  logic [3:0] bit_cnt;
  logic read_dir;
  logic prog_flag;
  logic [7:0] read_byte;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic byte_end;
  logic ack_rise;
  logic addr_hit;
  logic addr_miss;
  logic instr_done;
  logic data_done;
  logic frozen;
  logic drive_val;

  // Address byte check: fixed pattern, then select pin
  function automatic logic addr_match(input logic [7:0] b, input logic pin);
    addr_match = (b[7:2] == `OWS_ADDR_FIXED) && (b[1] == pin);
  endfunction

  // One read bit per slot, most significant first
  function automatic logic read_bit(input logic [7:0] b, input logic [3:0] idx);
    logic [2:0] pos;
    pos = 3'(`OWS_LAST_BIT - idx);
    read_bit = b[pos];
  endfunction

  // Link-side capture on the bus clock
  ows_rx_shift u_rx (
    .scl_i(SCL_I),
    .sda_i(SDA_I),
    .link(link.link)
  );

  // All pins cross into the core clock before the core logic uses them; the select strap too,
  // so a strap that settles late cannot tear an address compare
  ows_sync2 #(.W(5)) u_sync (
    .clk_i(CLK_I),
    .d_i({ADDR_SELECT_PIN_I, FUSE_OK_I, FUSE_DONE_I, SCL_I, SDA_I}),
    .q_o(s_pins)
  );

  assign scl_s = s_pins[`OWS_SCL_IDX];
  assign sda_s = s_pins[`OWS_SDA_IDX];
  assign done_s = s_pins[`OWS_DONE_IDX];
  assign ok_s = s_pins[`OWS_OK_IDX];
  assign sel_s = s_pins[`OWS_SEL_IDX];

  // Previous synchronised levels for edge detection
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Bus events; start and stop are data edges while clock is high
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;

  // Byte boundaries; the shifter settled at the real edge, long before
  // the synchronised rise, and holds until the next bus clock rise
  assign byte_end = scl_rise && (bit_cnt == `OWS_LAST_BIT) &&
                    (state != ows_pkg::ST_IDLE);
  assign ack_rise = scl_rise && (bit_cnt == `OWS_ACK_SLOT);
  assign addr_hit = byte_end && (state == ows_pkg::ST_ADDR) &&
                    addr_match(link.rx_byte, sel_s);
  assign addr_miss = byte_end && (state == ows_pkg::ST_ADDR) &&
                     !addr_match(link.rx_byte, sel_s);
  assign instr_done = byte_end && (state == ows_pkg::ST_INSTR);
  assign data_done = byte_end && (state == ows_pkg::ST_DATA);
  assign frozen = (FUSE_CHECK_O == `OWS_CHK_DONE);

  // Transaction sequencer; any start restarts at the address byte
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state <= ows_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
    end else if (start_cond) begin
      state <= ows_pkg::ST_ADDR;
      bit_cnt <= 4'h0;
    end else if (stop_cond) begin
      state <= ows_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
    end else if (scl_rise && state != ows_pkg::ST_IDLE) begin
      if (ack_rise) begin
        bit_cnt <= 4'h0;
        case (state)
          ows_pkg::ST_ADDR: begin
            // Read goes straight to data, write to instruction
            state <= read_dir ? ows_pkg::ST_READ : ows_pkg::ST_INSTR;
          end
          ows_pkg::ST_INSTR: begin
            state <= ows_pkg::ST_DATA;
          end
          ows_pkg::ST_DATA: begin
            state <= ows_pkg::ST_DATA;
          end
          default: begin
            // Single read byte; the master's answer ends our part
            state <= ows_pkg::ST_IDLE;
          end
        endcase
      end else if (addr_miss) begin
        state <= ows_pkg::ST_IDLE;
        bit_cnt <= 4'h0;
      end else begin
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end

  // Direction latched from the address byte
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      read_dir <= 1'b0;
    end else if (addr_hit) begin
      read_dir <= link.rx_byte[`OWS_DIR_BIT];
    end
  end

  // Programming flag from the instruction; other bits are ignored
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      prog_flag <= 1'b0;
    end else if (start_cond) begin
      prog_flag <= 1'b0;
    end else if (instr_done) begin
      prog_flag <= link.rx_byte[`OWS_PROG_BIT];
    end
  end

  // Snapshot for the read byte, so a fuse result mid-byte cannot tear it
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      read_byte <= 8'h00;
    end else if (addr_hit && link.rx_byte[`OWS_DIR_BIT]) begin
      read_byte <= {FUSE_CHECK_O, WIPER_CODE_O};
    end
  end

  // Level to put on the line during the next clock low period
  always_comb begin
    drive_val = 1'b0;
    if ((state == ows_pkg::ST_ADDR || state == ows_pkg::ST_INSTR ||
         state == ows_pkg::ST_DATA) && bit_cnt == `OWS_ACK_SLOT) begin
      drive_val = 1'b1;
    end else if (state == ows_pkg::ST_READ && bit_cnt < `OWS_ACK_SLOT) begin
      drive_val = !read_bit(read_byte, bit_cnt);
    end
  end

  // Data line only changes after a clock fall; start and stop release it
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      SDA_OE_N_O <= 1'b1;
    end else if (start_cond || stop_cond) begin
      SDA_OE_N_O <= 1'b1;
    end else if (scl_fall) begin
      SDA_OE_N_O <= !drive_val;
    end
  end

  // Open-drain: the driven level is always low
  always_ff @(posedge CLK_I) begin
    SDA_O <= 1'b0;
  end

  // Wiper register; midscale preset, frozen once fused
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      WIPER_CODE_O <= `OWS_WIPER_MID;
    end else if (data_done && !frozen && !FUSE_BLOW_O) begin
      WIPER_CODE_O <= link.rx_byte[5:0];
    end
  end

  // Fuse request held until the fuse hardware reports completion
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      FUSE_BLOW_O <= 1'b0;
    end else if (FUSE_BLOW_O && done_s) begin
      FUSE_BLOW_O <= 1'b0;
    end else if (data_done && prog_flag && !frozen && !done_s) begin
      FUSE_BLOW_O <= 1'b1;
    end
  end

  // Validation bits; a failed attempt leaves programming open for retry
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      FUSE_CHECK_O <= `OWS_CHK_READY;
    end else if (FUSE_BLOW_O && done_s) begin
      FUSE_CHECK_O <= ok_s ? `OWS_CHK_DONE : `OWS_CHK_FAIL;
    end
  end

  // Checks on the core clock
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  sequence s_addr_ok;
    addr_hit;
  endsequence

  sequence s_ack_low;
    ##[1:40] !SDA_OE_N_O;
  endsequence

  a_addr_ack_drive: assert property (s_addr_ok |-> s_ack_low)
    else $error("matched address not acknowledged");

  a_miss_stays_off: assert property (addr_miss |-> ##1 SDA_OE_N_O [*8])
    else $error("unaddressed device drove the data line");

  a_idle_no_drive: assert property (
    (state == ows_pkg::ST_IDLE && $past(state) == ows_pkg::ST_IDLE) |-> SDA_OE_N_O)
    else $error("data line driven while idle");

  a_drive_clk_low: assert property ($fell(SDA_OE_N_O) |-> !scl_s)
    else $error("data line pulled low while clock high");

  a_prog_flag_take: assert property (
    instr_done |=> prog_flag == $past(link.rx_byte[`OWS_PROG_BIT]))
    else $error("programming flag not taken from instruction top bit");

  a_wiper_update: assert property (
    (data_done && !frozen && !FUSE_BLOW_O) |=>
    WIPER_CODE_O == $past(link.rx_byte[5:0]))
    else $error("data byte did not update the wiper");

  a_fused_hold: assert property (frozen |=> $stable(WIPER_CODE_O))
    else $error("wiper changed after fusing");

  a_fuse_start: assert property (
    (data_done && prog_flag && !frozen && !FUSE_BLOW_O && !done_s) |=> FUSE_BLOW_O)
    else $error("programming flag did not start the fuse");

  a_fuse_result: assert property (
    (FUSE_BLOW_O && done_s) |=> !FUSE_BLOW_O &&
    FUSE_CHECK_O == ($past(ok_s) ? `OWS_CHK_DONE : `OWS_CHK_FAIL))
    else $error("validation bits wrong after fuse operation");

  a_read_snapshot: assert property (
    (addr_hit && link.rx_byte[`OWS_DIR_BIT]) |=>
    read_byte == {$past(FUSE_CHECK_O), $past(WIPER_CODE_O)})
    else $error("read byte does not hold validation then wiper bits");

  a_read_no_change: assert property (
    (state == ows_pkg::ST_READ && !FUSE_BLOW_O) |=>
    $stable(WIPER_CODE_O) && $stable(FUSE_CHECK_O))
    else $error("read changed device state");

  a_reserved_code: assert property (FUSE_CHECK_O != `OWS_CHK_RSVD)
    else $error("reserved validation code shown");

  // Start re-arms the slave from any state and stop returns it to idle; both let go of the line
  sequence s_start_seen;
    start_cond;
  endsequence

  sequence s_addr_armed;
    SDA_OE_N_O && state == ows_pkg::ST_ADDR && bit_cnt == 4'h0;
  endsequence

  a_start_rearm: assert property (s_start_seen |=> s_addr_armed)
    else $error("start did not re-arm the address byte");

  a_stop_idle: assert property (
    stop_cond |=> state == ows_pkg::ST_IDLE && SDA_OE_N_O)
    else $error("stop did not return the slave to idle");

  // Each clock fall decides the level for the next bit slot
  a_idle_fall_off: assert property (
    (state == ows_pkg::ST_IDLE && scl_fall) |=> SDA_OE_N_O)
    else $error("idle slave drove the data line");

  a_write_release: assert property (
    (scl_fall && bit_cnt != `OWS_ACK_SLOT &&
     (state == ows_pkg::ST_INSTR || state == ows_pkg::ST_DATA)) |=> SDA_OE_N_O)
    else $error("write bit not left to the master");

  a_read_bit_out: assert property (
    (state == ows_pkg::ST_READ && scl_fall && bit_cnt < `OWS_ACK_SLOT) |=>
    SDA_OE_N_O == read_bit(read_byte, bit_cnt))
    else $error("read bit out of order");

  // Byte order of the two transaction kinds
  a_read_straight: assert property (
    (state == ows_pkg::ST_ADDR && ack_rise && read_dir) |=> state == ows_pkg::ST_READ)
    else $error("read did not follow the address directly");

  a_instr_to_data: assert property (
    (state == ows_pkg::ST_INSTR && ack_rise) |=> state == ows_pkg::ST_DATA)
    else $error("instruction byte not followed by data");

  // Fuse request stays up until the fuse hardware answers
  a_blow_hold: assert property ((FUSE_BLOW_O && !done_s) |=> FUSE_BLOW_O)
    else $error("fuse request dropped before completion");

  a_frozen_no_blow: assert property (frozen |-> !FUSE_BLOW_O)
    else $error("fuse request while already fused");

endmodule
`default_nettype wire

// ===== src/ows_defines.svh
// Constants for the one-time-programmable wiper serial slave
`ifndef OWS_DEFINES_SVH
`define OWS_DEFINES_SVH

`define OWS_ADDR_FIXED 6'h16
`define OWS_DIR_BIT 0
`define OWS_PROG_BIT 7
`define OWS_WIPER_MID 6'h20
`define OWS_CHK_READY 2'h0
`define OWS_CHK_RSVD 2'h1
`define OWS_CHK_FAIL 2'h2
`define OWS_CHK_DONE 2'h3
`define OWS_LAST_BIT 4'h7
`define OWS_ACK_SLOT 4'h8
`define OWS_SDA_IDX 0
`define OWS_SCL_IDX 1
`define OWS_DONE_IDX 2
`define OWS_OK_IDX 3
`define OWS_SEL_IDX 4

`endif

// ===== src/ows_pkg.sv
// Types shared by the wiper serial slave
`default_nettype none
package ows_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_INSTR = 3'b010,
    ST_DATA  = 3'b011,
    ST_READ  = 3'b100
  } ows_state_t;
endpackage
`default_nettype wire

// ===== src/ows_link_if.sv
// Bundle between the serial-clock capture and the core
`timescale 1ns/1ps
`default_nettype none
interface ows_link_if;
  logic [7:0] rx_byte;
  modport link (output rx_byte);
  modport core (input rx_byte);
endinterface
`default_nettype wire

// ===== src/ows_sync2.sv
// Two-flop synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module ows_sync2 #(
  parameter int W = 4
) (
  input wire logic clk_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge clk_i) begin
    meta <= d_i;
    q_o <= meta;
  end
endmodule
`default_nettype wire

// ===== src/ows_rx_shift.sv
// Receive shifter clocked by the serial bus clock
`timescale 1ns/1ps
`default_nettype none
module ows_rx_shift (
  input wire logic scl_i,
  input wire logic sda_i,
  ows_link_if.link link
);
  // Data is stable while the clock is high, so the rising edge samples it
  always_ff @(posedge scl_i) begin
    link.rx_byte <= {link.rx_byte[6:0], sda_i};
  end
endmodule
`default_nettype wire

// ===== dv/ows_master.sv
// Behavioural two-wire bus master that drives the wiper slave
`timescale 1ns/1ps
`default_nettype none
module ows_master (
  output logic scl_o,
  output logic sda_pull_o,
  input wire logic sda_i,
  output logic [7:0] res_o,
  output logic res_v_o
);
  localparam int HALF = 40;
  // Clock idles high between frames; data line released to its pull-up
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
    res_o = 8'h00;
    res_v_o = 1'b0;
  end
  // Hand one result to the bench monitor
  task automatic report(input logic [7:0] v);
    res_o = v;
    res_v_o = 1'b1;
    #1 res_v_o = 1'b0;
  endtask
  // Data moves mid-low, so it is settled long before the rising clock
  task automatic bit_slot(input logic b, output logic s);
    scl_o = 1'b0;
    #(HALF/2) sda_pull_o = ~b;
    #(HALF/2) scl_o = 1'b1;
    s = sda_i;
    #HALF;
  endtask
  task automatic start();
    sda_pull_o = 1'b1;
    #HALF;
  endtask
  // Low before the tenth clock, then rise while it is high
  task automatic stop();
    scl_o = 1'b0;
    #(HALF/2) sda_pull_o = 1'b1;
    #(HALF/2) scl_o = 1'b1;
    #(HALF/2) sda_pull_o = 1'b0;
    #HALF;
  endtask
  // Eight bits out, then the slave's answer on the ninth clock
  task automatic send(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_slot(b[i], s);
    bit_slot(1'b1, s);
    report({7'h00, s});
  endtask
  // Eight bits in, then a not-acknowledge
  task automatic recv();
    logic [7:0] d;
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_slot(1'b1, d[i]);
    bit_slot(1'b1, s);
    report(d);
  endtask
endmodule
`default_nettype wire

// ===== dv/ows_wiper_slave_tb_top.sv
// Self-checking bench for the wiper serial slave
`timescale 1ns/1ps
`default_nettype none
`include "ows_defines.svh"
module ows_wiper_slave_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic scl, pull, sda, sda_o, oe_n, sel, done, ok, blow, res_v;
  logic [5:0] wiper, v;
  logic [1:0] chk;
  logic [7:0] res, e;
  logic [7:0] exp_q[$];
  int error_cnt = 0;
  int compares = 0;
  int seed = 39;
  always #4 clk = ~clk;
  // Open-drain data wire with pull-up; a slave driving high reads as released
  assign sda = (pull || (!oe_n && !sda_o)) ? 1'b0 : 1'b1;
  ows_wiper_slave dut (.CLK_I(clk), .RST_I(rst), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE_N_O(oe_n), .ADDR_SELECT_PIN_I(sel),
    .FUSE_DONE_I(done), .FUSE_OK_I(ok), .FUSE_BLOW_O(blow),
    .WIPER_CODE_O(wiper), .FUSE_CHECK_O(chk));
  ows_master m (.scl_o(scl), .sda_pull_o(pull), .sda_i(sda), .res_o(res),
    .res_v_o(res_v));
  task automatic close_out();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] ex, input logic [7:0] got);
    compares++;
    if (got !== ex) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, ex, got);
    end
  endtask
  // Oldest note is the one the bus result answers
  always @(posedge res_v) begin
    if (exp_q.size() == 0) begin
      error_cnt++;
      $display("FAIL bus result expected note seen none");
    end else begin
      e = exp_q.pop_front();
      check("bus result", e, res);
    end
  end
  // Fuse hardware stand-in; slow enough that the frame ends first
  always @(posedge clk) begin
    if (blow === 1'b1 && done === 1'b0) begin
      repeat (20) @(posedge clk);
      #1 done = 1'b1;
      wait (blow === 1'b0);
      repeat (2) @(posedge clk);
      #1 done = 1'b0;
    end
  end
  task automatic frame(input logic [7:0] a, input logic a_ack);
    m.start();
    exp_q.push_back({7'h00, a_ack});
    m.send(a);
  endtask
  task automatic put(input logic [7:0] b);
    exp_q.push_back(8'h00);
    m.send(b);
  endtask
  task automatic read_back(input logic [7:0] ex, input logic bad);
    frame({`OWS_ADDR_FIXED, sel ^ bad, 1'b1}, bad);
    exp_q.push_back(bad ? 8'hff : ex);
    m.recv();
    m.stop();
  endtask
  task automatic port_chk(input logic [5:0] w, input logic [1:0] c, input int n);
    repeat (n) @(posedge clk);
    #1;
    check("wiper", {2'h0, w}, {2'h0, wiper});
    check("fuse check", {6'h00, c}, {6'h00, chk});
    check("fuse blow", 8'h00, {7'h00, blow});
  endtask
  initial begin
    sel = 1'b1;
    done = 1'b0;
    ok = 1'b0;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    port_chk(`OWS_WIPER_MID, `OWS_CHK_READY, 4);
    read_back({`OWS_CHK_READY, `OWS_WIPER_MID}, 1'b0);
    $display("test reset done");
    // Several data bytes under one instruction, noise in the upper bits
    frame({`OWS_ADDR_FIXED, sel, 1'b0}, 1'b0);
    put({1'b0, 7'($random(seed))});
    for (int i = 0; i < 4; i++) begin
      v = 6'($random(seed));
      put({2'($random(seed)), v});
      port_chk(v, `OWS_CHK_READY, 1);
    end
    m.stop();
    $display("test repeated write done");
    // Other select level: no answer, no drive, no change
    frame({`OWS_ADDR_FIXED, ~sel, 1'b0}, 1'b1);
    exp_q.push_back(8'h01);
    m.send(8'h15);
    m.stop();
    read_back(8'h00, 1'b1);
    port_chk(v, `OWS_CHK_READY, 4);
    $display("test select done");
    // Failed burn reports retry code, second burn succeeds
    for (int k = 0; k < 2; k++) begin
      ok = k[0];
      v = 6'($random(seed));
      frame({`OWS_ADDR_FIXED, sel, 1'b0}, 1'b0);
      put({1'b1, 7'($random(seed))});
      put({2'h0, v});
      check("fuse blow", 8'h01, {7'h00, blow});
      m.stop();
      port_chk(v, k[0] ? `OWS_CHK_DONE : `OWS_CHK_FAIL, 30);
    end
    $display("test fuse done");
    // Writes after fusing are still acked but leave the wiper alone
    frame({`OWS_ADDR_FIXED, sel, 1'b0}, 1'b0);
    put(8'h00);
    put({2'h0, ~v});
    m.stop();
    port_chk(v, `OWS_CHK_DONE, 4);
    read_back({`OWS_CHK_DONE, v}, 1'b0);
    read_back({`OWS_CHK_DONE, v}, 1'b0);
    port_chk(v, `OWS_CHK_DONE, 4);
    $display("test frozen done");
    close_out();
  end
  // Whole run is near 20 us of bus traffic
  initial begin
    #300us;
    error_cnt++;
    $display("FAIL watchdog expected finish seen timeout");
    close_out();
  end
endmodule
`default_nettype wire
